/* dv/initiator_model.sv */
// Initiator model that takes inquiry bytes, promptly or with stalls.
`timescale 1ns/10ps
module initiator_model (
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic       slow,
  input  wire logic       in_valid,
  input  wire logic [7:0] in_data,
  output logic            in_ready
);
  logic [15:0] pat_q;
  logic [7:0]  rx_q [$];
  // The long gap in the pattern is there so the FIFO fills until it refuses.
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pat_q    <= 16'h00F1;
      in_ready <= 1'b0;
    end else begin
      if (in_valid && in_ready) begin
        rx_q.push_back(in_data);
      end
      pat_q    <= {pat_q[0], pat_q[15:1]};
      in_ready <= slow ? pat_q[0] : 1'b1;
    end
  end
endmodule

/* dv/inq_assertions.sv */
// Checker of the inquiry responder port behaviour.
`timescale 1ns/10ps
module inq_checker (
  input wire logic       sys_clk,
  input wire logic       rst_b,
  input wire logic       cdb_valid,
  input wire logic [7:0] cdb_byte,
  input wire logic       endorser_fitted,
  input wire logic       imgproc_fitted,
  input wire logic       unit_attn_in,
  input wire logic       data_ready,
  input wire logic       data_valid,
  input wire logic [7:0] data_byte,
  input wire logic       done,
  input wire logic [7:0] status,
  input wire logic [3:0] sense_key,
  input wire logic [7:0] sense_asc,
  input wire logic       unit_attn_out,
  input wire logic       busy
);
  // ------
  // Port relations
  // ------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  a_attn_kept: assert property ($past(rst_b) |-> unit_attn_out == $past(unit_attn_in))
    else $error("attention copy lost");
  a_byte_hold: assert property (data_valid && !data_ready |=> data_valid && $stable(data_byte))
    else $error("byte dropped while stalled");
  a_done_pulse: assert property (done |=> !done)
    else $error("done longer than one cycle");
  a_check_sense: assert property (done && status == inq_pkg::ST_CHECK |->
    sense_key == inq_pkg::SK_ILLEGAL && sense_asc == inq_pkg::ASC_INV_FIELD)
    else $error("check without invalid field sense");
  a_status_code: assert property (done |-> status == inq_pkg::ST_GOOD ||
    status == inq_pkg::ST_CHECK)
    else $error("unknown status code");
  a_status_hold: assert property (!done |-> $stable(status) && $stable(sense_key))
    else $error("status moved between commands");
  a_idle_quiet: assert property (!busy |-> !data_valid)
    else $error("data offered while idle");
  a_done_busy: assert property (done |-> busy)
    else $error("done outside a command");
  a_cmd_ends: assert property ($rose(busy) |-> ##[1:1000] done)
    else $error("command never completed");
endmodule
bind inquiry_responder inq_checker inq_checker_i (.sys_clk(sys_clk), .rst_b(rst_b),
  .cdb_valid(cdb_valid), .cdb_byte(cdb_byte), .endorser_fitted(endorser_fitted),
  .imgproc_fitted(imgproc_fitted), .unit_attn_in(unit_attn_in), .data_ready(data_ready),
  .data_valid(data_valid), .data_byte(data_byte), .done(done), .status(status),
  .sense_key(sense_key), .sense_asc(sense_asc), .unit_attn_out(unit_attn_out), .busy(busy));

/* dv/scsi_inquiry_responder_tb_top.sv */
// Self-checking bench of the inquiry responder driven through its top ports.
`timescale 1ns/10ps
module scsi_inquiry_responder_tb_top;
  localparam logic [63:0] VID = 64'h564E_4452_5820_2020; // Arbitrary value.
  localparam logic [31:0] REV = 32'h3941_2020;           // Arbitrary value.
  logic         sys_clk = 1'b0;
  logic         rst_b, cdb_valid, endorser_fitted, imgproc_fitted, unit_attn_in, slow;
  logic [7:0]   cdb_byte, data_byte, status, sense_asc;
  logic [3:0]   sense_key;
  logic         data_valid, done, unit_attn_out, busy, data_ready;
  logic [127:0] pid [4];
  logic [31:0]  lf = 32'h0000_4641;
  int           err_count = 0;
  int           tests_run = 0;
  inquiry_responder #(.VENDOR_ID(VID), .REVISION(REV)) inquiry_responder_i (
    .sys_clk(sys_clk), .rst_b(rst_b), .cdb_valid(cdb_valid), .cdb_byte(cdb_byte),
    .endorser_fitted(endorser_fitted), .imgproc_fitted(imgproc_fitted),
    .unit_attn_in(unit_attn_in), .data_ready(data_ready),
    .data_valid(data_valid), .data_byte(data_byte), .done(done), .status(status),
    .sense_key(sense_key), .sense_asc(sense_asc), .unit_attn_out(unit_attn_out), .busy(busy));
  initiator_model initiator_model_i (.sys_clk(sys_clk), .rst_b(rst_b), .slow(slow),
    .in_valid(data_valid), .in_data(data_byte), .in_ready(data_ready));
  // 200 MHz clock.
  always #2.5 sys_clk = ~sys_clk;
  // ------
  // Helpers
  // ------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Expected byte with a care flag in bit 8; product id bytes are judged apart.
  function automatic logic [8:0] exp_byte(input int i, input logic vpd, input logic nl);
    if (nl) return (i == 0) ? 9'h17F : 9'h100;
    if (vpd) begin
      case (i)
        0: return 9'h106;
        1: return 9'h1F0;
        2: return 9'h100;
        3: return 9'h100;
        4: return 9'h15F;
        default: return 9'h100;
      endcase
    end
    case (i) inside
      0: return 9'h106;
      1, 5, 6: return 9'h100;
      2: return 9'h102;
      3: return 9'h102;
      4: return 9'h15B;
      7: return 9'h110;
      [8:15]: return {1'b1, VID[8*(15-i) +: 8]};
      [32:35]: return {1'b1, REV[8*(35-i) +: 8]};
      [56:95]: return 9'h100;
      default: return 9'h000;
    endcase
  endfunction
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // One whole command: six descriptor bytes, completion, then the drained bytes.
  task automatic run_cmd(input logic [7:0] op, input logic evpd, input logic [7:0] page,
                         input logic [7:0] alloc, input logic nolun);
    logic [7:0] cdb [6];
    logic       bad, nl;
    logic [8:0] e;
    int         want;
    bad  = op != 8'h12 || (evpd ? page != 8'hF0 : page != 8'h00);
    nl   = nolun && !bad && !evpd;
    cdb  = '{op, {nl ? 3'h5 : 3'h0, 4'h0, evpd}, page, 8'h00, alloc, 8'h00};
    want = bad ? 0 : ((alloc < (evpd ? 100 : 96)) ? alloc : (evpd ? 100 : 96));
    initiator_model_i.rx_q.delete();
    for (int k = 0; k < 6; k++) begin
      @(negedge sys_clk);
      cdb_valid = 1'b1;
      cdb_byte  = cdb[k];
    end
    @(negedge sys_clk);
    cdb_valid = 1'b0;
    for (int k = 0; k < 3000 && done !== 1'b1; k++) @(negedge sys_clk);
    chk("done", 8'h01, {7'h00, done});
    chk("status", bad ? 8'h02 : 8'h00, status);
    chk("sense key", bad ? 8'h05 : 8'h00, {4'h0, sense_key});
    chk("sense code", bad ? 8'h24 : 8'h00, sense_asc);
    chk("attention kept", {7'h00, unit_attn_in}, {7'h00, unit_attn_out});
    for (int k = 0; k < 300 && data_valid !== 1'b0; k++) @(negedge sys_clk);
    @(negedge sys_clk);
    chk("busy after end", 8'h00, {7'h00, busy});
    chk("byte count", want[7:0], 8'(initiator_model_i.rx_q.size()));
    for (int i = 0; i < initiator_model_i.rx_q.size(); i++) begin
      e = exp_byte(i, evpd, nl);
      if (e[8]) chk("data byte", e[7:0], initiator_model_i.rx_q[i]);
      if (!bad && !evpd && !nl && want >= 32 && i >= 16 && i < 32)
        pid[{endorser_fitted, imgproc_fitted}][8*(31-i) +: 8] = initiator_model_i.rx_q[i];
    end
  endtask
  // ------
  // Main sequence: corner cases first, then random commands
  // ------
  initial begin
    rst_b = 1'b0;
    cdb_valid = 1'b0;
    cdb_byte = 8'h00;
    {endorser_fitted, imgproc_fitted, unit_attn_in, slow} = 4'h0;
    repeat (8) @(negedge sys_clk);
    rst_b = 1'b1;
    for (int k = 0; k < 48; k++) begin
      lf = lfsr(lf);
      {endorser_fitted, imgproc_fitted} = (k < 4) ? k[1:0] : lf[29:28];
      unit_attn_in = lf[30];
      slow = (k < 4) ? 1'b1 : lf[21];
      case (k)
        0, 1, 2, 3: run_cmd(8'h12, 1'b0, 8'h00, 8'hFF, 1'b0);
        4: run_cmd(8'h12, 1'b1, 8'hF0, 8'hFF, 1'b0);
        5: run_cmd(8'h12, 1'b0, 8'h00, 8'h05, 1'b0);
        6: run_cmd(8'h12, 1'b1, 8'h00, 8'hFF, 1'b0);
        7: run_cmd(8'h12, 1'b0, 8'h01, 8'h24, 1'b0);
        8: run_cmd(8'h12, 1'b0, 8'h00, 8'h60, 1'b1);
        9: run_cmd(8'h12, 1'b1, 8'hF0, 8'h00, 1'b0);
        10: run_cmd(8'h03, 1'b0, 8'h00, 8'hFF, 1'b0);
        default: run_cmd((lf[7:4] == 4'h0) ? lf[15:8] : 8'h12, lf[16],
                         (lf[18:17] == 2'h1) ? 8'hF0 : (lf[18:17] == 2'h2) ? lf[27:20] : 8'h00,
                         lf[31:24], lf[20:19] == 2'h3);
      endcase
    end
    for (int a = 0; a < 4; a++)
      for (int b = a + 1; b < 4; b++)
        chk("product id differs", 8'h01, {7'h00, pid[a] !== pid[b]});
    give_verdict();
  end
  // A hang is cut short at 50000 cycles, well past the longest expected run.
  initial begin
    #250_000;
    err_count++;
    give_verdict();
  end
endmodule

/* hdl/byte_fifo.sv */
// Parameterised valid/ready FIFO.
`timescale 1ns/10ps
module byte_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  input  wire logic   sys_clk,
  input  wire logic   rst_b,
  byte_stream_if.snk  in_s,
  output logic        out_valid,
  input  wire logic   out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0]   cnt_q, cnt_d;
  logic          push, pop;

  // Occupancy and pointer arithmetic; full stalls the writer.
  always_comb begin
    push = in_s.valid && (cnt_q != (AW+1)'(DEPTH));
    pop  = out_ready && (cnt_q != '0);
    wp_d = push ? wp_q + 1'b1 : wp_q;
    rp_d = pop ? rp_q + 1'b1 : rp_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end
  assign in_s.ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid  = (cnt_q != '0);
  assign out_data   = mem[rp_q];

  // Storage array has no reset, only pointers and count do.
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wp_q] <= in_s.data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
  end
endmodule

/* hdl/byte_stream_if.sv */
// Valid/ready byte stream carrier between the responder and its FIFO.
`timescale 1ns/10ps
interface byte_stream_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* hdl/inq_pkg.sv */
// Package of constants for the inquiry responder.
package inq_pkg;
  // ---------------------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OP_INQUIRY     = 8'h12;
  localparam logic [7:0] VPD_PAGE       = 8'hF0;
  localparam int         CDB_LEN        = 6;
  localparam int         SEL_BIT        = 0;
  // ---------------------------------------------------------------------------
  // Standard data fields
  // ---------------------------------------------------------------------------
  localparam logic [7:0] BYTE0_NO_UNIT  = 8'h7F;
  localparam logic [2:0] QUAL_CONNECTED = 3'h0;
  localparam logic [4:0] TYPE_SCANNER   = 5'h06;
  localparam logic [1:0] ISO_VER        = 2'h0;
  localparam logic [2:0] ECMA_VER       = 3'h0;
  localparam logic [2:0] ANSI_VER       = 3'h2;
  localparam logic [3:0] RESP_FMT       = 4'h2;
  localparam logic [7:0] ADD_LEN        = 8'h5B;
  localparam logic [7:0] CAP_FLAGS      = 8'h10;
  localparam int         STD_LEN        = 96;
  localparam int         VPD_LEN        = 100;
  localparam int         RSV_FIRST      = 56;
  localparam int         RSV_LAST       = 95;
  localparam logic [7:0] ASCII_SPACE    = 8'h20;
  // ---------------------------------------------------------------------------
  // Status and sense, FIFO depth
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ST_GOOD        = 8'h00;
  localparam logic [7:0] ST_CHECK       = 8'h02;
  localparam logic [3:0] SK_ILLEGAL     = 4'h5;
  localparam logic [7:0] ASC_INV_FIELD  = 8'h24;
  localparam int         FIFO_DEPTH     = 8;
endpackage

/* hdl/inquiry_responder.sv */
// Inquiry command interpreter: CDB decode, response stream, status and sense.
//
// Summary of operation
// - Six-byte descriptor, opcode 12h, fields decoded.
// - Select bit set returns page by code.
// - Unsupported page gives check, illegal, invalid field.
// - Select clear returns standard data, nonzero page errors.
// - Only page F0h is supported.
// - Check status only when data undeliverable.
// - Pending unit attention stays, inquiry still runs.
// - 36 mandatory bytes; bytes 56-95 zero.
// - Unsupported unit returns 7Fh in byte 0; the VPD page ignores the LUN field and still returns 06h.
// - Scanner unit: qualifier 000b, type 06h.
// - Version byte: ISO 0, ECMA 0, ANSI 2.
// - Async notify and terminate bits zero.
// - Response data format is 2h.
// - Additional length 91, never adjusted.
// - Never send beyond allocation length.
// - Product id suffix varies with options.
`timescale 1ns/10ps
module inquiry_responder #(
  parameter logic [63:0]  VENDOR_ID  = 64'h5645_4E44_4F52_2020, // Arbitrary value.
  parameter logic [31:0]  REVISION   = 32'h3030_2020,           // Arbitrary value.
  parameter logic [127:0] PROD_BASE  = 128'h5343_414E_2020_2020_2020_2020_2020_2020,
  parameter int           SUFFIX_POS = 4,
  parameter logic [2:0]   UNIT_LUN   = 3'h0
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic       cdb_valid,
  input  wire logic [7:0] cdb_byte,
  input  wire logic       endorser_fitted,
  input  wire logic       imgproc_fitted,
  input  wire logic       unit_attn_in,
  input  wire logic       data_ready,
  output logic            data_valid,
  output logic [7:0]      data_byte,
  output logic            done,
  output logic [7:0]      status,
  output logic [3:0]      sense_key,
  output logic [7:0]      sense_asc,
  output logic            unit_attn_out,
  output logic            busy
);
  // ---------------------------------------------------------------------------
  // Data path overview
  // ---------------------------------------------------------------------------
  // The six descriptor bytes are captured one per strobe while the sequencer is
  // idle; strobes that arrive during a command are ignored, so the host must wait
  // for done before it starts the next descriptor.
  // Response bytes are generated from the byte position, the page select, the LUN field and the option inputs, which keeps the
  // generator free of any memory; the cost is a wide mux that a faster clock
  // might need to pipeline.
  // The FIFO decouples generation from a host that stalls, and the skid register
  // behind it keeps data_valid and data_byte straight from flops.
  // Completion waits until both the FIFO and the skid register are empty, so
  // done never arrives while a byte is still on offer.
  // Status and sense hold their values until the next completion; the unit
  // attention input is only mirrored and never cleared by this block.

  // Gray codes along capture, decode, stream and end.
  typedef enum logic [1:0] {
    S_CDB  = 2'b00,
    S_DEC  = 2'b01,
    S_SEND = 2'b11,
    S_END  = 2'b10
  } st_e;

  st_e        st_q, st_d;
  logic [2:0] idx_q, idx_d;
  logic [7:0] cdb_q [6];
  logic [7:0] cdb_d [6];
  logic [6:0] pos_q, pos_d;
  logic [6:0] lim_q, lim_d;
  logic       vpd_q, vpd_d;
  logic       err_q, err_d;
  logic       done_q, done_d;
  logic       busy_q, busy_d;
  logic [7:0] stat_q, stat_d;
  logic [3:0] sk_q, sk_d;
  logic [7:0] asc_q, asc_d;
  logic       ua_q;
  logic [7:0] gen_byte;
  logic [127:0] prod_id;
  logic [7:0] alloc;
  logic [6:0] full_len;
  byte_stream_if #(.W(8)) fin ();
  logic       fo_valid;
  logic [7:0] fo_data;
  // Skid register of the output stage, read by the completion test as well.
  logic       ov_q, ov_d;
  logic [7:0] ob_q, ob_d;
  logic       f_pop;

  // ---------------------------------------------------------------------------
  // Product id and response byte generator
  // ---------------------------------------------------------------------------
  // Option letters are written into the id at a fixed column.
  always_comb begin
    prod_id = PROD_BASE;
    prod_id[127-8*SUFFIX_POS -: 8]     = "d";
    prod_id[127-8*(SUFFIX_POS+1) -: 8] = endorser_fitted ? "e" : (imgproc_fitted ? "i" : "m");
    prod_id[127-8*(SUFFIX_POS+2) -: 8] = (endorser_fitted && imgproc_fitted) ? "i" :
                                         ((endorser_fitted || imgproc_fitted) ? "m" : " ");
    prod_id[127-8*(SUFFIX_POS+3) -: 8] = (endorser_fitted && imgproc_fitted) ? "m" : " ";
  end

  // Byte at position pos_q; VPD page body beyond its header reads as zero.
  always_comb begin
    gen_byte = 8'h00;
    if (vpd_q) begin
      unique case (pos_q)
        7'd0:    gen_byte = {inq_pkg::QUAL_CONNECTED, inq_pkg::TYPE_SCANNER};
        7'd1:    gen_byte = inq_pkg::VPD_PAGE;
        7'd4:    gen_byte = 8'(inq_pkg::VPD_LEN - 5);
        default: gen_byte = 8'h00;
      endcase
    end else if (cdb_q[1][7:5] != UNIT_LUN) begin
      gen_byte = (pos_q == 7'd0) ? inq_pkg::BYTE0_NO_UNIT : 8'h00;
    end else if (pos_q == 7'd0) begin
      gen_byte = {inq_pkg::QUAL_CONNECTED, inq_pkg::TYPE_SCANNER};
    end else if (pos_q == 7'd1 || pos_q == 7'd5 || pos_q == 7'd6) begin
      gen_byte = 8'h00;
    end else if (pos_q == 7'd2) begin
      gen_byte = {inq_pkg::ISO_VER, inq_pkg::ECMA_VER, inq_pkg::ANSI_VER};
    end else if (pos_q == 7'd3) begin
      gen_byte = {4'h0, inq_pkg::RESP_FMT};
    end else if (pos_q == 7'd4) begin
      gen_byte = inq_pkg::ADD_LEN;
    end else if (pos_q == 7'd7) begin
      gen_byte = inq_pkg::CAP_FLAGS;
    end else if (pos_q >= 7'd8 && pos_q <= 7'd15) begin
      gen_byte = VENDOR_ID[63-8*(pos_q-7'd8) -: 8];
    end else if (pos_q >= 7'd16 && pos_q <= 7'd31) begin
      gen_byte = prod_id[127-8*(pos_q-7'd16) -: 8];
    end else if (pos_q >= 7'd32 && pos_q <= 7'd35) begin
      gen_byte = REVISION[31-8*(pos_q-7'd32) -: 8];
    end else if (pos_q >= 7'(inq_pkg::RSV_FIRST)) begin
      gen_byte = 8'h00;
    end else begin
      gen_byte = inq_pkg::ASCII_SPACE;
    end
  end

  // ---------------------------------------------------------------------------
  // Command sequencer
  // ---------------------------------------------------------------------------
  // Next-state logic for capture, decode, stream and completion.
  always_comb begin
    st_d   = st_q;
    idx_d  = idx_q;
    cdb_d  = cdb_q;
    pos_d  = pos_q;
    lim_d  = lim_q;
    vpd_d  = vpd_q;
    err_d  = err_q;
    done_d = 1'b0;
    busy_d = (st_q != S_CDB);
    stat_d = stat_q;
    sk_d   = sk_q;
    asc_d  = asc_q;
    alloc  = cdb_q[4];
    full_len = vpd_q ? 7'(inq_pkg::VPD_LEN) : 7'(inq_pkg::STD_LEN);
    unique case (st_q)
      S_CDB: begin
        if (cdb_valid) begin
          cdb_d[idx_q] = cdb_byte;
          if (idx_q == 3'(inq_pkg::CDB_LEN - 1)) begin
            idx_d = 3'h0;
            st_d  = S_DEC;
          end else begin
            idx_d = idx_q + 3'h1;
          end
        end
      end
      S_DEC: begin
        vpd_d = cdb_q[1][inq_pkg::SEL_BIT];
        // Error only when the requested data cannot be delivered.
        if (cdb_q[0] != inq_pkg::OP_INQUIRY) begin
          err_d = 1'b1;
        end else if (cdb_q[1][inq_pkg::SEL_BIT]) begin
          err_d = (cdb_q[2] != inq_pkg::VPD_PAGE);
        end else begin
          err_d = (cdb_q[2] != 8'h00);
        end
        pos_d = 7'h0;
        lim_d = 7'((alloc < 8'(full_len)) ? alloc : 8'(full_len));
        if (cdb_q[1][inq_pkg::SEL_BIT]) begin
          lim_d = 7'((alloc < 8'(inq_pkg::VPD_LEN)) ? alloc : 8'(inq_pkg::VPD_LEN));
        end else begin
          lim_d = 7'((alloc < 8'(inq_pkg::STD_LEN)) ? alloc : 8'(inq_pkg::STD_LEN));
        end
        st_d = S_SEND;
      end
      S_SEND: begin
        if (err_q || pos_q == lim_q) begin
          st_d = S_END;
        end else if (fin.ready) begin
          pos_d = pos_q + 7'h1;
        end
      end
      S_END: begin
        // The last byte may still sit in the skid register; wait for it too.
        if (!fo_valid && !ov_q) begin
          done_d = 1'b1;
          stat_d = err_q ? inq_pkg::ST_CHECK : inq_pkg::ST_GOOD;
          sk_d   = err_q ? inq_pkg::SK_ILLEGAL : 4'h0;
          asc_d  = err_q ? inq_pkg::ASC_INV_FIELD : 8'h00;
          st_d   = S_CDB;
        end
      end
    endcase
  end

  // Push generated bytes into the FIFO while streaming is allowed.
  assign fin.valid = (st_q == S_SEND) && !err_q && (pos_q != lim_q);
  assign fin.data  = gen_byte;

  // Registers of the sequencer; the unit attention is only mirrored, never cleared here.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q   <= S_CDB;
      idx_q  <= 3'h0;
      for (int i = 0; i < 6; i++) begin
        cdb_q[i] <= 8'h00;
      end
      pos_q  <= 7'h0;
      lim_q  <= 7'h0;
      vpd_q  <= 1'b0;
      err_q  <= 1'b0;
      done_q <= 1'b0;
      busy_q <= 1'b0;
      stat_q <= 8'h00;
      sk_q   <= 4'h0;
      asc_q  <= 8'h00;
      ua_q   <= 1'b0;
    end else begin
      st_q   <= st_d;
      idx_q  <= idx_d;
      cdb_q  <= cdb_d;
      pos_q  <= pos_d;
      lim_q  <= lim_d;
      vpd_q  <= vpd_d;
      err_q  <= err_d;
      done_q <= done_d;
      busy_q <= busy_d;
      stat_q <= stat_d;
      sk_q   <= sk_d;
      asc_q  <= asc_d;
      ua_q   <= unit_attn_in;
    end
  end

  // ---------------------------------------------------------------------------
  // Output buffer and registered output stage
  // ---------------------------------------------------------------------------

  // The skid register keeps data outputs straight from flops.
  always_comb begin
    f_pop = fo_valid && (!ov_q || data_ready);
    ov_d  = ov_q;
    ob_d  = ob_q;
    if (data_ready && ov_q) begin
      ov_d = 1'b0;
    end
    if (f_pop) begin
      ov_d = 1'b1;
      ob_d = fo_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ov_q <= 1'b0;
      ob_q <= 8'h00;
    end else begin
      ov_q <= ov_d;
      ob_q <= ob_d;
    end
  end

  byte_fifo #(.W(8), .DEPTH(inq_pkg::FIFO_DEPTH)) u_fifo (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .in_s      (fin),
    .out_valid (fo_valid),
    .out_ready (f_pop),
    .out_data  (fo_data)
  );

  assign data_valid    = ov_q;
  assign data_byte     = ob_q;
  assign done          = done_q;
  assign status        = stat_q;
  assign sense_key     = sk_q;
  assign sense_asc     = asc_q;
  assign unit_attn_out = ua_q;
  assign busy          = busy_q;
endmodule
